// *** core/module_soft_control.v ***
/*
 * Module-side soft control: interrupt gating by masks, bus answer enable by
 * module select, power level sequencing, transmitter disable.
 * Assumes the serial bus engine gives one-cycle strobes on clk_sys after a
 * transaction's stop bit; pins and the serial clock are asynchronous.
 */
// Notes on behaviour
// [R1] Set mask stops flag interrupt within 100 ms
// [R2] Cleared mask resumes flag interrupt within 100 ms
// [R3] Select low: answer bus within 100 us
// [R4] Select high: stop answering within 100 us
// [R5] Power-down bit one: low power within 100 ms; in ST_INIT the bit is held off until init ends
// [R6] Power-down bit zero: functional within 300 ms
// [R7] Ready: clear not-ready bit, raise interrupt
// [R8] Deadlines start at serial clock fall after stop
// [R9] Transmit-disable high or open disables transmitter
// [R10] Clear-on-read releases interrupt within 500 us
// [R11] Flag condition sets flag, interrupt within 200 ms
// [R12] Low power request: low power within 100 us; in ST_INIT the request is held off until init ends
// [R13] Reset release: functional within 2000 ms
// [R14] Interrupt low when unmasked flag set
`timescale 1ns/1ns
`default_nettype none
`include "soft_ctrl_defines.vh"

module module_soft_control #(
   parameter NFLAG = 8,
   parameter [`CNT_W-1:0] INIT_CYC = `CYC_MS(`T_INIT_MS),
   parameter [`CNT_W-1:0] PDOFF_CYC = `CYC_MS(`T_PDOWN_OFF_MS)
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             reset_n,
   // Module pins (asynchronous)
   input  wire             module_select_n,
   input  wire             module_reset_n,
   input  wire             low_power_request,
   input  wire             transmit_disable,
   input  wire             scl_in,
   output reg              interrupt_out_n,
   output reg              module_present_n,
   // Bus engine strobes, after stop bit
   input  wire             write_done,
   input  wire             read_done,
   // Written control bits
   input  wire [NFLAG-1:0] mask_bits,
   input  wire             power_down_bit,
   // Flag events and clear-on-read selection
   input  wire [NFLAG-1:0] flag_event,
   input  wire [NFLAG-1:0] flag_read_clear,
   // Status and controls to the rest of the module
   output reg  [NFLAG-1:0] flags,
   output reg              data_not_ready,
   output reg              bus_answer_en,
   output reg              low_power,
   output reg              tx_enable
);

   localparam ST_INIT = 2'b00;   // Coming out of reset
   localparam ST_RUN  = 2'b01;   // Fully functional
   localparam ST_LOW  = 2'b10;   // Lower power level
   localparam ST_WAKE = 2'b11;   // Returning from low power

   reg  [1:0] st_q;        // Power state
   reg        first_q;     // Timer not yet started in this state
   wire       init_done;   // Init period over

   // Two-flop synchronisers for the pins
   reg  [4:0] s1_q;   // First stage, read only by second
   reg  [4:0] s2_q;   // Second stage
   reg        scl_q;  // Delayed serial clock for edge find
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         s1_q  <= 5'h1F;
         s2_q  <= 5'h1F;
         scl_q <= 1'b1;
      end
      else
      begin
         s1_q  <= {scl_in, module_select_n, module_reset_n, transmit_disable,
                   low_power_request};
         s2_q  <= s1_q;
         scl_q <= s2_q[4];
      end
   end
   wire sel_n_s = s2_q[3];   // Module select, synchronised
   wire mrst_s  = s2_q[2];   // Module reset, synchronised
   wire transmit_disable_s  = s2_q[1];   // Transmit disable, synchronised
   wire lpm_s   = s2_q[0];   // Low power request, synchronised
   wire scl_fall = scl_q & ~s2_q[4];

   // Arm on stop bit, fire at next serial clock fall
   reg wr_arm_q;   // Write finished, waiting for fall
   reg rd_arm_q;   // Read finished, waiting for fall
   reg [NFLAG-1:0] rd_clr_q;   // Flags read in that transaction
   reg [NFLAG-1:0] msk_q;      // Mask bits in force
   reg pd_q;                   // Power-down bit in force
   reg mrst_q;                 // Previous module reset level
   // [R8] Deadlines from fall
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         wr_arm_q <= 1'b0;
         rd_arm_q <= 1'b0;
         rd_clr_q <= {NFLAG{1'b0}};
         msk_q    <= {NFLAG{1'b0}};
         pd_q     <= 1'b0;
         mrst_q   <= 1'b1;
      end
      else
      begin
         mrst_q <= mrst_s;
         if (write_done)
            wr_arm_q <= 1'b1;
         else if (scl_fall)
            wr_arm_q <= 1'b0;
         if (read_done)
         begin
            rd_arm_q <= 1'b1;
            rd_clr_q <= rd_clr_q | flag_read_clear;
         end
         else if (scl_fall)
         begin
            // Selection is used by this fall, so no later read reuses it
            rd_arm_q <= 1'b0;
            rd_clr_q <= {NFLAG{1'b0}};
         end
         // [R1] [R2] Mask applied
         if (wr_arm_q && scl_fall)
         begin
            msk_q <= mask_bits;
            pd_q  <= power_down_bit;
         end
      end
   end
   wire wr_fire = wr_arm_q & scl_fall;
   wire rd_fire = rd_arm_q & scl_fall;

   // Sticky flags, set wins over clear
   // [R11] Flag set
   // [R10] Clear on read
   always @(posedge clk_sys)
   begin
      if (!reset_n)
         flags <= {NFLAG{1'b0}};
      else
         flags <= flag_event | (flags & ~(rd_fire ? rd_clr_q : {NFLAG{1'b0}}));
   end

   // Interrupt output from flags and not-ready edge
   reg ready_int_q;   // Set by the ready transition
   // [R14] Interrupt gating
   always @(posedge clk_sys)
   begin
      if (!reset_n)
         interrupt_out_n <= 1'b1;
      else
         interrupt_out_n <= ~(|(flags & ~msk_q) | ready_int_q);
   end

   // Bus answer follows synchronised select
   // [R3] [R4] Select response
   always @(posedge clk_sys)
   begin
      if (!reset_n)
         bus_answer_en <= 1'b0;
      else
         bus_answer_en <= ~sel_n_s;
   end

   // Transmitter enabled only with a low control
   // [R9] Transmit disable
   always @(posedge clk_sys)
   begin
      if (!reset_n)
         tx_enable <= 1'b0;
      else
         tx_enable <= ~transmit_disable_s & (st_q == ST_RUN);
   end

   // Power sequencing timers
   reg st_start;   // Load the wake or init timer
   wire tm_done;   // Timer expired
   delay_timer #(
      .COUNT (INIT_CYC)
   ) u_init_tm (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (st_start & (st_q == ST_INIT)),
      .done    (init_done)
   );
   delay_timer #(
      .COUNT (PDOFF_CYC)
   ) u_wake_tm (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .start   (st_start & (st_q != ST_INIT)),
      .done    (tm_done)
   );

   // Power state machine
   wire      go_low = pd_q | lpm_s;
   always @(*)
   begin
      st_start = first_q & ((st_q == ST_INIT) | (st_q == ST_WAKE));
   end
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         st_q           <= ST_INIT;
         first_q        <= 1'b1;
         data_not_ready <= 1'b1;
         low_power      <= 1'b0;
         ready_int_q    <= 1'b0;
         module_present_n <= 1'b0;
      end
      else
      begin
         module_present_n <= 1'b0;
         first_q <= 1'b0;
         // Any read ends the ready interrupt, at its serial clock fall
         if (rd_fire)
            ready_int_q <= 1'b0;
         if (!mrst_s)
         begin
            // Module reset also leaves the lower power level
            st_q           <= ST_INIT;
            first_q        <= 1'b1;
            data_not_ready <= 1'b1;
            low_power      <= 1'b0;
         end
         else
         begin
            case (st_q)
               // [R13] Init after reset release
               ST_INIT:
               begin
                  if (mrst_s && !mrst_q)
                     first_q <= 1'b1;
                  if (init_done)
                  begin
                     st_q           <= ST_RUN;
                     data_not_ready <= 1'b0;
                     // [R7] Ready indication
                     ready_int_q    <= 1'b1;
                  end
               end
               // [R5] [R12] Drop power
               ST_RUN:
               begin
                  if (go_low)
                  begin
                     st_q      <= ST_LOW;
                     low_power <= 1'b1;
                  end
               end
               ST_LOW:
               begin
                  if (!go_low)
                  begin
                     st_q           <= ST_WAKE;
                     low_power      <= 1'b0;
                     first_q        <= 1'b1;
                     data_not_ready <= 1'b1;
                  end
               end
               // [R6] Return to functional
               ST_WAKE:
               begin
                  if (go_low)
                  begin
                     st_q      <= ST_LOW;
                     low_power <= 1'b1;
                  end
                  else if (tm_done)
                  begin
                     st_q           <= ST_RUN;
                     data_not_ready <= 1'b0;
                     ready_int_q    <= 1'b1;
                  end
               end
               default:
                  st_q <= ST_INIT;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// *** inc/soft_ctrl_defines.vh ***
/*
 * Timing figures and status bit positions for the module soft control block.
 * Assumes a 100 MHz core clock; counts are derived from times in their unit.
 */
`ifndef SOFT_CTRL_DEFINES_VH
`define SOFT_CTRL_DEFINES_VH

// Core clock rate
`define CLK_HZ              100000000
// Deadlines, in their printed units
`define T_MASK_MS           100
`define T_SEL_US            100
`define T_PDOWN_ON_MS       100
`define T_PDOWN_OFF_MS      300
`define T_CLR_US            500
`define T_FLAG_MS           200
`define T_LPM_US            100
`define T_INIT_MS           2000
// Cycle counts, exact at this clock; the longest fits the counter width
`define CYC_MS(t)           ((t) * (`CLK_HZ / 1000))
`define CYC_US(t)           ((t) * (`CLK_HZ / 1000000))
// Status byte 2 data-not-ready position
`define STAT_NOT_READY_BIT  0
// Counter width
`define CNT_W               28

`endif

// *** core/delay_timer.v ***
/*
 * Restartable countdown: a pulse on start loads the count, done pulses once
 * when it reaches zero. Assumes start comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "soft_ctrl_defines.vh"

module delay_timer #(
   parameter [`CNT_W-1:0] COUNT = 1
) (
   // Clock and reset
   input  wire               clk_sys,
   input  wire               reset_n,
   // Control
   input  wire               start,
   output reg                done
);

   reg  [`CNT_W-1:0] cnt_q;   // Remaining cycles
   reg               run_q;   // Counting

   // Load on start, count down, pulse at end
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         cnt_q <= {`CNT_W{1'b0}};
         run_q <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            cnt_q <= COUNT - 1'b1;
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            if (cnt_q == {`CNT_W{1'b0}})
            begin
               run_q <= 1'b0;
               done  <= 1'b1;
            end
            else
               cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// *** tb/soft_ctrl_monitor.sv ***
/* Port checker for the soft control block.
   Assumes the bench serial clock falls within 40 cycles of each strobe. */
`timescale 1ns/1ns
`default_nettype none
`include "soft_ctrl_defines.vh"
module soft_ctrl_monitor #(
   parameter NFLAG = 8,
   parameter [`CNT_W-1:0] INIT_CYC = 28'h00000C8
) (
   // Clock and reset
   input wire logic             clk_sys,
   input wire logic             reset_n,
   // Pins, strobes and written bits
   input wire logic             module_select_n,
   input wire logic             module_reset_n,
   input wire logic             low_power_request,
   input wire logic             transmit_disable,
   input wire logic             write_done,
   input wire logic             read_done,
   input wire logic             power_down_bit,
   input wire logic [NFLAG-1:0] mask_bits,
   input wire logic [NFLAG-1:0] flag_event,
   input wire logic [NFLAG-1:0] flag_read_clear,
   // Block outputs
   input wire logic             interrupt_out_n,
   input wire logic [NFLAG-1:0] flags,
   input wire logic             data_not_ready,
   input wire logic             bus_answer_en,
   input wire logic             low_power,
   input wire logic             tx_enable
);
   localparam int T_INIT = INIT_CYC + 10;  // Init bound with margin
   logic [NFLAG-1:0] seen_q;               // Last unmasked flag set
   logic [5:0]       quiet_q;              // Cycles it stayed unchanged
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Count cycles of steady unmasked flags
   always_ff @(posedge clk_sys)
   begin
      seen_q <= flags & ~mask_bits;
      if (!reset_n || (flags & ~mask_bits) != seen_q)
         quiet_q <= 6'h00;
      else if (quiet_q != 6'h3F)
         quiet_q <= quiet_q + 6'h01;
   end
   AST_SEL_ON: assert property (!module_select_n [*6] |-> bus_answer_en)
      else $error("bus not answered while selected");
   AST_SEL_OFF: assert property (module_select_n [*6] |-> !bus_answer_en)
      else $error("bus answered while deselected");
   AST_TX_OFF: assert property (transmit_disable [*4] |-> !tx_enable)
      else $error("transmitter on while disabled");
   AST_LPM: assert property (low_power_request [*5] |-> low_power)
      else $error("low power request ignored");
   AST_PDOWN: assert property (write_done && power_down_bit |-> ##[1:40] low_power)
      else $error("power-down write ignored");
   AST_CLR: assert property (read_done && |flag_read_clear |->
      ##[1:40] !(|(flags & flag_read_clear)))
      else $error("read flags not cleared");
   AST_READY: assert property ($fell(data_not_ready) |-> ##[0:2] !interrupt_out_n)
      else $error("no interrupt on ready");
   AST_INIT: assert property ($rose(module_reset_n) |->
      ##[1:T_INIT] (!data_not_ready || !module_reset_n || low_power))
      else $error("init too slow");
   AST_FLAG: assert property (|flag_event && module_reset_n |-> ##[1:2] |flags)
      else $error("flag not set on event");
   AST_INT: assert property (quiet_q == 6'h3F && |seen_q |-> !interrupt_out_n)
      else $error("unmasked flag without interrupt");
   CV_SEL: cover property ($fell(module_select_n));
   CV_LP: cover property ($rose(low_power));
   CV_RDY: cover property ($fell(data_not_ready));
endmodule
bind module_soft_control soft_ctrl_monitor #(.NFLAG(NFLAG), .INIT_CYC(INIT_CYC))
   i_soft_ctrl_monitor (.clk_sys, .reset_n, .module_select_n, .module_reset_n,
   .low_power_request, .transmit_disable, .write_done, .read_done, .power_down_bit,
   .mask_bits, .flag_event, .flag_read_clear, .interrupt_out_n, .flags,
   .data_not_ready, .bus_answer_en, .low_power, .tx_enable);
`default_nettype wire

// *** tb/host_bus_model.sv ***
/* Host side of the two-wire bus: stop strobes, written bits, serial clock.
   Assumes the serial clock idles high and runs only inside a frame. */
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
   // Core clock
   input wire logic  clk_sys,
   // Toward the block
   output logic       scl_in,
   output logic       write_done,
   output logic       read_done,
   output logic       power_down_bit,
   output logic [7:0] mask_bits,
   output logic [7:0] flag_read_clear
);
   // Idle bus, nothing masked
   initial
   begin
      scl_in = 1'b1;
      write_done = 1'b0;
      read_done = 1'b0;
      power_down_bit = 1'b0;
      mask_bits = 8'h00;
      flag_read_clear = 8'h00;
   end
   // One write or read: stop strobe with its bits
   task automatic xfer(input logic wr, input logic pd, input logic [7:0] val);
   begin
      @(posedge clk_sys);
      write_done <= wr;
      read_done <= !wr;
      mask_bits <= wr ? val : mask_bits;
      power_down_bit <= wr ? pd : power_down_bit;
      flag_read_clear <= wr ? flag_read_clear : val;
      @(posedge clk_sys);
      write_done <= 1'b0;
      read_done <= 1'b0;
      repeat (2)
      begin
         #63 scl_in = 1'b0;
         #62 scl_in = 1'b1;
      end
      repeat (4) @(posedge clk_sys);
   end
   endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for the soft control block.
   Assumes shortened init and wake counts in the design. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam [27:0] INIT = 28'h00000C8;  // Shortened init count
   localparam [27:0] PDOFF = 28'h0000064; // Shortened wake count
   logic       clk_sys, reset_n, module_select_n, module_reset_n;
   logic       low_power_request, transmit_disable, scl_in, write_done;
   logic       read_done, power_down_bit, interrupt_out_n, module_present_n;
   logic       data_not_ready, bus_answer_en, low_power, tx_enable;
   logic [7:0] mask_bits, flag_event, flag_read_clear, flags;
   int         num_errors = 0, checks_done = 0;
   module_soft_control #(.NFLAG(8), .INIT_CYC(INIT), .PDOFF_CYC(PDOFF))
      i_module_soft_control (.*);
   host_bus_model i_host_bus_model (.*);
   // Core clock, 10 ns
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Watchdog
   initial
   begin
      #100000;
      num_errors++;
      print_verdict;
   end
   // Counts and verdict
   task print_verdict;
   begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // Wait n edges, then settle to the falling edge
   task tick(input int n);
   begin
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   end
   endtask
   // Main sequence
   initial
   begin
      {reset_n, module_select_n, module_reset_n, low_power_request} = 4'h6;
      transmit_disable = 1'b1;
      flag_event = 8'h00;
      tick(2);
      `CHK("present", 1'b0, module_present_n)
      `CHK("int_rst", 1'b1, interrupt_out_n)
      @(posedge clk_sys);
      reset_n <= 1'b1;
      transmit_disable <= 1'b0;
      tick(INIT + 20);
      `CHK("ready", 1'b0, data_not_ready)
      `CHK("int_ready", 1'b0, interrupt_out_n)
      `CHK("tx_on", 1'b1, tx_enable)
      i_host_bus_model.xfer(1'b0, 1'b0, 8'h00);
      tick(2);
      `CHK("int_read", 1'b1, interrupt_out_n)
      @(posedge clk_sys);
      transmit_disable <= 1'b1;
      tick(6);
      `CHK("tx_off", 1'b0, tx_enable)
      @(posedge clk_sys);
      transmit_disable <= 1'b0;
      module_select_n <= 1'b0;
      tick(6);
      `CHK("sel_on", 1'b1, bus_answer_en)
      @(posedge clk_sys);
      module_select_n <= 1'b1;
      tick(6);
      `CHK("sel_off", 1'b0, bus_answer_en)
      @(posedge clk_sys);
      flag_event <= 8'h04;
      @(posedge clk_sys);
      flag_event <= 8'h00;
      tick(3);
      `CHK("flag", 8'h04, flags)
      `CHK("int_flag", 1'b0, interrupt_out_n)
      i_host_bus_model.xfer(1'b1, 1'b0, 8'h04);
      tick(2);
      `CHK("int_mask", 1'b1, interrupt_out_n)
      i_host_bus_model.xfer(1'b1, 1'b0, 8'h00);
      tick(70);
      `CHK("int_unmask", 1'b0, interrupt_out_n)
      i_host_bus_model.xfer(1'b0, 1'b0, 8'h04);
      tick(2);
      `CHK("flag_clr", 8'h00, flags)
      `CHK("int_clr", 1'b1, interrupt_out_n)
      i_host_bus_model.xfer(1'b1, 1'b1, 8'h00);
      tick(2);
      `CHK("pd_on", 1'b1, low_power)
      i_host_bus_model.xfer(1'b1, 1'b0, 8'h00);
      tick(PDOFF + 20);
      `CHK("pd_off", 1'b0, low_power)
      `CHK("wake_ready", 1'b0, data_not_ready)
      `CHK("tx_wake", 1'b1, tx_enable)
      @(posedge clk_sys);
      low_power_request <= 1'b1;
      tick(6);
      `CHK("lpm", 1'b1, low_power)
      @(posedge clk_sys);
      low_power_request <= 1'b0;
      tick(PDOFF + 20);
      `CHK("lpm_off", 1'b0, low_power)
      @(posedge clk_sys);
      module_reset_n <= 1'b0;
      tick(6);
      `CHK("init_hold", 1'b1, data_not_ready)
      @(posedge clk_sys);
      module_reset_n <= 1'b1;
      tick(INIT + 20);
      `CHK("init_done", 1'b0, data_not_ready)
      print_verdict;
   end
endmodule
`default_nettype wire
